// ===== verilog/bmf_pkg.sv
// Constants, register map and carrier types of the message framer
package bmf_pkg;
	// Control codes on the serial channel
	localparam logic [7:0] BMF_ENQ = 8'h05;
	localparam logic [7:0] BMF_ACK = 8'h06;
	localparam logic [7:0] BMF_NAK = 8'h15;
	// Register word indices; byte address is four times the index
	localparam logic [11:0] BMF_REG_CTRL = 12'h010;
	localparam logic [11:0] BMF_REG_CMD = 12'h011;
	localparam logic [11:0] BMF_REG_STATUS = 12'h012;
	localparam logic [11:0] BMF_REG_TXLEN = 12'h013;
	localparam logic [11:0] BMF_REG_RXLEN = 12'h014;
	localparam logic [11:0] BMF_REG_TXRESULT = 12'h257;
	localparam logic [11:0] BMF_REG_RXRESULT = 12'h258;
	// Buffer windows, selected by index bits 11:9
	localparam logic [2:0] BMF_TXBUF_REGION = 3'h2;
	localparam logic [2:0] BMF_RXBUF_REGION = 3'h3;
	// Control register fields and reset value
	localparam int BMF_CTRL_SUM_BIT = 0;
	localparam int BMF_CTRL_BYTE_BIT = 1;
	localparam logic [1:0] BMF_CTRL_RESET = 2'h1;
	// Command register fields (write-one pulses)
	localparam int BMF_CMD_READ_DONE_BIT = 0;
	localparam int BMF_CMD_SEND_BIT = 1;
	// Status register fields
	localparam int BMF_ST_READ_REQ_BIT = 0;
	localparam int BMF_ST_RX_ERR_BIT = 1;
	localparam int BMF_ST_TX_BUSY_BIT = 2;
	localparam int BMF_ST_TX_DONE_BIT = 3;
	localparam int BMF_ST_TX_NAK_BIT = 4;
	// Error codes this end sends in a negative acknowledge
	localparam logic [15:0] BMF_ERR_SUM = 16'h7f01;
	localparam logic [15:0] BMF_ERR_LEN = 16'h7f02;
	// One byte on the serial byte stream
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} bmf_byte_s;
endpackage

// ===== verilog/bmf_framer.sv
// Bidirectional message framer with Avalon-MM register and buffer access
`timescale 1ns/1ps
module bmf_framer
	import bmf_pkg::*;
#(
	parameter int DEPTH = 512
)
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [11:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWriteData,
	output logic [31:0] avsReadData,
	output logic avsWaitRequest,
	input wire bmf_byte_s rxIn,
	output bmf_byte_s txOut,
	input wire logic txReady
);
	localparam int AW = $clog2(DEPTH);
	// Largest data portion the receive bank holds, in bytes
	localparam logic [16:0] RX_CAP = 17'(2 * DEPTH);

	typedef enum {R_IDLE, R_LENL, R_LENH, R_DATA, R_SUML, R_SUMH,
		R_HOLD} bmf_rx_e;
	typedef enum {O_IDLE, O_ENQ, O_LENL, O_LENH, O_DATA, O_SUML, O_SUMH,
		O_RSP} bmf_out_e;

	// Receive memory is two banks; software reads one while the other fills
	logic [15:0] rxMem [2*DEPTH];
	logic [15:0] txMem [DEPTH];
	logic bank_q; // Bank that software sees

	// Bus slave state
	logic busAck_q; // High in the second cycle of an access
	logic [31:0] rdData_q;
	logic [31:0] rdMux;
	logic [1:0] ctrl_q; // Sum enable and byte unit
	logic [15:0] txLen_q; // Length to send
	logic [15:0] rxLen_q; // Length of the last good message
	logic [15:0] txResult_q;
	logic [15:0] rxResult_q;
	logic wrTake; // Write takes effect this edge
	logic readDonePulse;
	logic sendPulse;

	// Receive side
	bmf_rx_e rxState_q;
	logic [15:0] rxLenHold_q;
	logic [16:0] rxBytes_q; // Expected data bytes
	logic [16:0] byteCnt_q; // Data bytes taken so far
	logic [7:0] lowHold_q; // Low byte waiting for its partner
	logic [15:0] rxSum_q;
	logic [7:0] sumLow_q;
	logic lenOk_q;
	logic readReq_q;
	logic rspPend_q; // Answer waiting to go out
	logic rspNak_q;
	logic [15:0] rspCode_q;
	logic [16:0] lenBytes;
	logic lastData;
	logic rxWe;
	logic [AW:0] rxWaddr;
	logic [15:0] rxWdata;
	logic ctrlSlot; // Between messages, control codes are recognised
	logic rspByte; // Byte belongs to the answer of our own message
	logic rxFree;

	// Transmit side
	bmf_out_e outState_q;
	logic [16:0] txIdx_q;
	logic [15:0] txSum_q;
	logic [1:0] rspIdx_q;
	logic [7:0] curByte;
	logic [16:0] txBytes;
	logic accept;
	logic outStart;
	logic msgSent;
	logic rspDone;
	logic txBusy_q;
	logic txPend_q;
	logic txAwait_q;
	logic txDone_q;
	logic txNak_q;
	logic [1:0] nakPhase_q;
	logic [7:0] nakLow_q;
	bmf_byte_s txOut_q;

	// Number of data bytes a length field stands for
	function automatic logic [16:0] unitBytes(input logic [15:0] len,
		input logic byteUnit);
		unitBytes = byteUnit ? {1'b0, len} : {len, 1'b0};
	endfunction

	// Two-cycle bus access: one wait state, then data and write commit
	assign avsWaitRequest = (avsRead | avsWrite) & ~busAck_q;
	assign avsReadData = rdData_q;
	assign wrTake = avsWrite & busAck_q;
	assign readDonePulse = wrTake && avsAddress == BMF_REG_CMD &&
		avsWriteData[BMF_CMD_READ_DONE_BIT];
	assign sendPulse = wrTake && avsAddress == BMF_REG_CMD &&
		avsWriteData[BMF_CMD_SEND_BIT];

	// Handshake tracker for the wait state
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			busAck_q <= 1'b0;
		else
			busAck_q <= (avsRead | avsWrite) & ~busAck_q;
	end

	// Read decode; unmapped indices read as zero
	always_comb
	begin
		rdMux = 32'h0000_0000;
		if (avsAddress[11:9] == BMF_RXBUF_REGION)
			rdMux[15:0] = rxMem[{bank_q, avsAddress[AW-1:0]}];
		else if (avsAddress[11:9] == BMF_TXBUF_REGION)
			rdMux[15:0] = txMem[avsAddress[AW-1:0]];
		else
		begin
			case (avsAddress)
				BMF_REG_CTRL: rdMux[1:0] = ctrl_q;
				BMF_REG_STATUS:
				begin
					rdMux[BMF_ST_READ_REQ_BIT] = readReq_q;
					// Error flag stays low: faults answer by NAK only
					rdMux[BMF_ST_RX_ERR_BIT] = 1'b0;
					rdMux[BMF_ST_TX_BUSY_BIT] = txBusy_q;
					rdMux[BMF_ST_TX_DONE_BIT] = txDone_q;
					rdMux[BMF_ST_TX_NAK_BIT] = txNak_q;
				end
				BMF_REG_TXLEN: rdMux[15:0] = txLen_q;
				BMF_REG_RXLEN: rdMux[15:0] = rxLen_q;
				BMF_REG_TXRESULT: rdMux[15:0] = txResult_q;
				BMF_REG_RXRESULT: rdMux[15:0] = rxResult_q;
				default: rdMux = 32'h0000_0000;
			endcase
		end
	end

	// Read data captured in the wait cycle, valid when waitrequest drops
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
			rdData_q <= 32'h0000_0000;
		else if (avsRead && !busAck_q)
			rdData_q <= rdMux;
	end

	// Software-written configuration
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			ctrl_q <= BMF_CTRL_RESET;
			txLen_q <= 16'h0000;
		end
		else if (wrTake && avsAddress == BMF_REG_CTRL)
			ctrl_q <= avsWriteData[1:0];
		else if (wrTake && avsAddress == BMF_REG_TXLEN && !txBusy_q)
			txLen_q <= avsWriteData[15:0];
	end

	// Transmit buffer, written only by software
	always_ff @(posedge clk_sys)
	begin
		if (wrTake && avsAddress[11:9] == BMF_TXBUF_REGION)
			txMem[avsAddress[AW-1:0]] <= avsWriteData[15:0];
	end

	// Bytes that answer our own message are taken apart from reception
	assign ctrlSlot = rxState_q == R_IDLE || rxState_q == R_HOLD;
	assign rspByte = txAwait_q && (nakPhase_q != 2'd0 || (ctrlSlot &&
		(rxIn.data == BMF_ACK || rxIn.data == BMF_NAK)));
	assign rxFree = rxIn.valid && !rspByte;
	assign lenBytes = unitBytes({rxIn.data, rxLenHold_q[7:0]},
		ctrl_q[BMF_CTRL_BYTE_BIT]);
	assign lastData = byteCnt_q + 17'd1 == rxBytes_q;

	// Word assembly into the hidden bank
	always_comb
	begin
		rxWe = 1'b0;
		rxWaddr = {~bank_q, byteCnt_q[AW:1]};
		// Low byte first; a lone last byte gets a zero upper half
		rxWdata = byteCnt_q[0] ? {rxIn.data, lowHold_q}
			: {8'h00, rxIn.data};
		if (rxFree && rxState_q == R_DATA && lenOk_q &&
			(byteCnt_q[0] || lastData))
			rxWe = 1'b1;
	end

	// Receive memory write port
	always_ff @(posedge clk_sys)
	begin
		if (rxWe)
			rxMem[rxWaddr] <= rxWdata;
	end

	// Reception sequence, read request and answer scheduling
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			rxState_q <= R_IDLE;
			rxLenHold_q <= 16'h0000;
			rxBytes_q <= 17'h0_0000;
			byteCnt_q <= 17'h0_0000;
			lowHold_q <= 8'h00;
			rxSum_q <= 16'h0000;
			sumLow_q <= 8'h00;
			lenOk_q <= 1'b0;
			readReq_q <= 1'b0;
			bank_q <= 1'b0;
			rxLen_q <= 16'h0000;
			rxResult_q <= 16'h0000;
			rspPend_q <= 1'b0;
			rspNak_q <= 1'b0;
			rspCode_q <= 16'h0000;
		end
		else
		begin
			// A finished answer clears the pending flag; new set wins below
			if (rspDone)
				rspPend_q <= 1'b0;
			case (rxState_q)
				R_IDLE:
				begin
					// Only the enquiry opens a message; stray bytes drop
					if (rxFree && rxIn.data == BMF_ENQ)
					begin
						rxState_q <= R_LENL;
						rxSum_q <= 16'h0000;
						byteCnt_q <= 17'h0_0000;
					end
				end
				R_LENL:
				begin
					if (rxFree)
					begin
						rxLenHold_q[7:0] <= rxIn.data;
						rxSum_q <= rxSum_q + {8'h00, rxIn.data};
						rxState_q <= R_LENH;
					end
				end
				R_LENH:
				begin
					if (rxFree)
					begin
						rxLenHold_q[15:8] <= rxIn.data;
						rxSum_q <= rxSum_q + {8'h00, rxIn.data};
						rxBytes_q <= lenBytes;
						// Too long for the bank: consume, then refuse
						lenOk_q <= lenBytes <= RX_CAP;
						if (lenBytes == 17'h0_0000)
							rxState_q <= ctrl_q[BMF_CTRL_SUM_BIT] ? R_SUML
								: R_HOLD;
						else
							rxState_q <= R_DATA;
					end
				end
				R_DATA:
				begin
					if (rxFree)
					begin
						lowHold_q <= rxIn.data;
						rxSum_q <= rxSum_q + {8'h00, rxIn.data};
						byteCnt_q <= byteCnt_q + 17'd1;
						if (lastData)
							rxState_q <= ctrl_q[BMF_CTRL_SUM_BIT] ? R_SUML
								: R_HOLD;
					end
				end
				R_SUML:
				begin
					if (rxFree)
					begin
						sumLow_q <= rxIn.data;
						rxState_q <= R_SUMH;
					end
				end
				R_SUMH:
				begin
					if (rxFree)
						rxState_q <= R_HOLD;
				end
				R_HOLD:
				begin
					// Controller finished reading: acknowledge now
					if (readReq_q && readDonePulse)
					begin
						readReq_q <= 1'b0;
						rspPend_q <= 1'b1;
						rspNak_q <= 1'b0;
						rxState_q <= R_IDLE;
					end
				end
				default: rxState_q <= R_IDLE;
			endcase
			// Judge the message once its last byte is in
			if (rxFree && ((rxState_q == R_SUMH) || (rxState_q == R_DATA &&
				lastData && !ctrl_q[BMF_CTRL_SUM_BIT]) ||
				(rxState_q == R_LENH && lenBytes == 17'h0_0000 &&
				!ctrl_q[BMF_CTRL_SUM_BIT])))
			begin
				if (!((rxState_q == R_LENH) ? (lenBytes <= RX_CAP)
					: lenOk_q))
				begin
					rspPend_q <= 1'b1;
					rspNak_q <= 1'b1;
					rspCode_q <= BMF_ERR_LEN;
					rxResult_q <= BMF_ERR_LEN;
					rxState_q <= R_IDLE;
				end
				else if (rxState_q == R_SUMH &&
					{rxIn.data, sumLow_q} != rxSum_q)
				begin
					rspPend_q <= 1'b1;
					rspNak_q <= 1'b1;
					rspCode_q <= BMF_ERR_SUM;
					rxResult_q <= BMF_ERR_SUM;
					rxState_q <= R_IDLE;
				end
				else
				begin
					// Good message: show the new bank and ask for a read
					bank_q <= ~bank_q;
					rxLen_q <= (rxState_q == R_LENH)
						? {rxIn.data, rxLenHold_q[7:0]} : rxLenHold_q;
					readReq_q <= 1'b1;
				end
			end
		end
	end

	// Outgoing byte for the current sending state
	assign txBytes = unitBytes(txLen_q, ctrl_q[BMF_CTRL_BYTE_BIT]);
	always_comb
	begin
		case (outState_q)
			O_ENQ: curByte = BMF_ENQ;
			O_LENL: curByte = txLen_q[7:0];
			O_LENH: curByte = txLen_q[15:8];
			O_DATA: curByte = txIdx_q[0] ? txMem[txIdx_q[AW:1]][15:8]
				: txMem[txIdx_q[AW:1]][7:0];
			O_SUML: curByte = txSum_q[7:0];
			O_SUMH: curByte = txSum_q[15:8];
			O_RSP:
			begin
				if (rspIdx_q == 2'd0)
					curByte = rspNak_q ? BMF_NAK : BMF_ACK;
				else if (rspIdx_q == 2'd1)
					curByte = rspCode_q[7:0];
				else
					curByte = rspCode_q[15:8];
			end
			default: curByte = 8'h00;
		endcase
	end

	assign accept = txOut_q.valid & txReady;
	assign outStart = outState_q == O_IDLE && !rspPend_q && txPend_q;
	assign rspDone = accept && outState_q == O_RSP &&
		(rspIdx_q == 2'd2 || !rspNak_q);
	assign msgSent = accept && ((outState_q == O_SUMH) ||
		(!ctrl_q[BMF_CTRL_SUM_BIT] && ((outState_q == O_LENH &&
		txBytes == 17'h0_0000) || (outState_q == O_DATA &&
		txIdx_q + 17'd1 == txBytes))));
	assign txOut = txOut_q;

	// Output sequencer; answers go ahead of a new message
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			outState_q <= O_IDLE;
			txOut_q <= '0;
			txIdx_q <= 17'h0_0000;
			txSum_q <= 16'h0000;
			rspIdx_q <= 2'd0;
		end
		else if (outState_q == O_IDLE)
		begin
			rspIdx_q <= 2'd0;
			if (rspPend_q)
				outState_q <= O_RSP;
			else if (txPend_q)
			begin
				outState_q <= O_ENQ;
				txIdx_q <= 17'h0_0000;
				txSum_q <= 16'h0000;
			end
		end
		else if (!txOut_q.valid)
		begin
			// Present the byte, hold it until the sink takes it
			txOut_q.valid <= 1'b1;
			txOut_q.data <= curByte;
		end
		else if (accept)
		begin
			txOut_q.valid <= 1'b0;
			if (outState_q == O_LENL || outState_q == O_LENH ||
				outState_q == O_DATA)
				txSum_q <= txSum_q + {8'h00, curByte};
			if (msgSent || rspDone)
				outState_q <= O_IDLE;
			else
			begin
				case (outState_q)
					O_ENQ: outState_q <= O_LENL;
					O_LENL: outState_q <= O_LENH;
					O_LENH: outState_q <= (txBytes == 17'h0_0000) ? O_SUML
						: O_DATA;
					O_DATA:
					begin
						txIdx_q <= txIdx_q + 17'd1;
						if (txIdx_q + 17'd1 == txBytes)
							outState_q <= O_SUML;
					end
					O_SUML: outState_q <= O_SUMH;
					O_RSP: rspIdx_q <= rspIdx_q + 2'd1;
					default: outState_q <= O_IDLE;
				endcase
			end
		end
	end

	// Send command, partner's answer and transmit result
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			txBusy_q <= 1'b0;
			txPend_q <= 1'b0;
			txAwait_q <= 1'b0;
			txDone_q <= 1'b0;
			txNak_q <= 1'b0;
			nakPhase_q <= 2'd0;
			nakLow_q <= 8'h00;
			txResult_q <= 16'h0000;
		end
		else
		begin
			// A send command while busy is ignored
			if (sendPulse && !txBusy_q)
			begin
				txBusy_q <= 1'b1;
				txPend_q <= 1'b1;
				txDone_q <= 1'b0;
				txNak_q <= 1'b0;
			end
			if (outStart)
				txPend_q <= 1'b0;
			if (msgSent)
				txAwait_q <= 1'b1;
			if (rxIn.valid && rspByte)
			begin
				if (nakPhase_q == 2'd1)
				begin
					nakLow_q <= rxIn.data;
					nakPhase_q <= 2'd2;
				end
				else if (nakPhase_q == 2'd2)
				begin
					// Partner error code becomes completion status
					txResult_q <= {rxIn.data, nakLow_q};
					txNak_q <= 1'b1;
					txDone_q <= 1'b1;
					txBusy_q <= 1'b0;
					txAwait_q <= 1'b0;
					nakPhase_q <= 2'd0;
				end
				else if (rxIn.data == BMF_ACK)
				begin
					txResult_q <= 16'h0000;
					txDone_q <= 1'b1;
					txBusy_q <= 1'b0;
					txAwait_q <= 1'b0;
				end
				else
					nakPhase_q <= 2'd1;
			end
		end
	end
endmodule

// ===== tb/bmf_framer_assertions.sv
// Port checker for the message framer, bound onto its top module
`timescale 1ns/1ps
module bmf_framer_check
	import bmf_pkg::*;
#(
	parameter int DEPTH = 512
)
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [11:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWriteData,
	input wire logic [31:0] avsReadData,
	input wire logic avsWaitRequest,
	input wire bmf_byte_s rxIn,
	input wire bmf_byte_s txOut,
	input wire logic txReady
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// Command write that the slave commits at this edge
	wire logic cmdWr = avsWrite && !avsWaitRequest
		&& avsAddress == BMF_REG_CMD;
	// Exactly one wait state per access
	a_wait_once: assert property ((avsRead || avsWrite) && avsWaitRequest
		|=> !avsWaitRequest) else $error("wait state not one cycle");
	a_first_wait: assert property ((avsRead || avsWrite)
		&& !$past(avsRead || avsWrite) |-> avsWaitRequest)
		else $error("no wait state on new access");
	a_idle_ready: assert property (!(avsRead || avsWrite)
		|-> !avsWaitRequest) else $error("waitrequest while idle");
	// Read data moves only after a read
	a_rdata_hold: assert property ($changed(avsReadData) |-> $past(avsRead))
		else $error("read data changed without read");
	a_upper_zero: assert property (avsReadData[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	// A stalled byte keeps its value
	a_tx_hold: assert property (txOut.valid && !txReady
		|=> txOut.valid && $stable(txOut.data)) else $error("byte dropped");
	a_byte_gap: assert property (txOut.valid && txReady |=> !txOut.valid)
		else $error("no load cycle between bytes");
	a_send_enq: assert property (cmdWr && avsWriteData[1] |-> ##[1:60]
		txOut.valid && txOut.data == BMF_ENQ) else $error("no enquiry");
	a_ack_done: assert property (cmdWr && avsWriteData[0] |-> ##[1:60]
		txOut.valid && txOut.data == BMF_ACK) else $error("no acknowledge");
endmodule
bind bmf_framer bmf_framer_check #(.DEPTH(DEPTH)) i_check (.clk_sys,
	.rstn, .avsAddress, .avsRead, .avsWrite, .avsWriteData, .avsReadData,
	.avsWaitRequest, .rxIn, .txOut, .txReady);

// ===== tb/bmf_peer.sv
// Far-side serial device: sends frames and sinks bytes with stalls
`timescale 1ns/1ps
module bmf_peer
	import bmf_pkg::*;
(
	input wire logic clk_sys,
	input wire bmf_byte_s txOut,
	output bmf_byte_s rxIn,
	output logic txReady
);
	logic [7:0] dat [0:15]; // Data portion staged by the bench
	logic [1:0] stallCnt = 2'h0; // Stall phase counter
	initial rxIn = '{1'b0, 8'h00};
	// Ready low one cycle in four, so the framer must hold bytes
	always @(posedge clk_sys)
		stallCnt <= stallCnt + 2'h1;
	assign txReady = stallCnt != 2'h3;
	// One byte per call; idle data is inverted so no stale value lingers
	task put(input logic [7:0] b);
		@(posedge clk_sys);
		rxIn <= '{1'b1, b};
		@(posedge clk_sys);
		rxIn <= '{1'b0, ~b};
	endtask
	// Whole message; the requested number of junk bytes trail it, sum on or off
	task msg(input logic [15:0] lenF, input int n, input bit sumOn,
		input bit bad, input int junk);
		logic [15:0] s;
		s = 16'(lenF[7:0]) + 16'(lenF[15:8]);
		put(BMF_ENQ);
		put(lenF[7:0]);
		put(lenF[15:8]);
		for (int i = 0; i < n; i++)
		begin
			put(dat[i]);
			s = s + 16'(dat[i]);
		end
		// Corrupted sum only when a scenario asks for it
		if (sumOn)
		begin
			s = s + 16'(bad);
			put(s[7:0]);
			put(s[15:8]);
		end
		repeat (junk) put(8'h41);
	endtask
	// Refusal with an error code from the user range
	task nak(input logic [15:0] code);
		put(BMF_NAK);
		put(code[7:0]);
		put(code[15:8]);
	endtask
endmodule

// ===== tb/bmf_framer_bench.sv
// Self-checking bench for the message framer
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] %0t got %h want %h", $time, g, e); end end
module bmf_framer_bench
	import bmf_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic [11:0] avsAddress = 12'h000;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] avsWriteData = 32'h0000_0000;
	logic [31:0] avsReadData;
	logic avsWaitRequest;
	bmf_byte_s rxIn;
	bmf_byte_s txOut;
	logic txReady;
	int err_count = 0;
	int checked = 0;
	logic [15:0] qRd [$]; // Expected read data, oldest first
	logic [15:0] qTx [$]; // Expected serial bytes, oldest first
	logic [15:0] eRd, eTx, prev;
	logic [31:0] rnd = 32'hfe37_6056; // Fixed seed
	always #12.5 clk_sys = ~clk_sys;
	bmf_framer #(.DEPTH(16)) i_dut (.clk_sys, .rstn, .avsAddress, .avsRead,
		.avsWrite, .avsWriteData, .avsReadData, .avsWaitRequest, .rxIn,
		.txOut, .txReady);
	bmf_peer i_peer (.clk_sys, .txOut, .rxIn, .txReady);
	function automatic logic [31:0] nextRnd(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Watcher: each result taken off the oldest note
	always @(posedge clk_sys)
	begin
		if (avsRead && !avsWaitRequest && qRd.size() > 0)
		begin
			eRd = qRd.pop_front();
			`CHK(avsReadData[15:0], eRd)
		end
		// Every accepted byte must have been foreseen
		if (txOut.valid && txReady)
		begin
			// An unforeseen byte carries an impossible note, so it always fails
			eTx = (qTx.size() > 0) ? qTx.pop_front() : 16'hffff;
			`CHK({8'h00, txOut.data}, eTx)
		end
	end
	task end_sim;
		$display("Comparisons %0d, errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Avalon access held until waitrequest is seen low
	task avs(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		avsAddress <= a;
		avsWrite <= wr;
		avsRead <= !wr;
		avsWriteData <= d;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (avsWaitRequest && n < 50);
		if (avsWaitRequest)
		begin
			err_count++;
			end_sim;
		end
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [15:0] d);
		avs(1'b1, a, {16'h0000, d});
	endtask
	task rd(input logic [11:0] a, input logic [15:0] e);
		qRd.push_back(e);
		avs(1'b0, a, 32'h0000_0000);
	endtask
	task expTx(input logic [7:0] b);
		qTx.push_back({8'h00, b});
	endtask
	// Bounded wait until every expected byte went out
	task waitTx;
		int n;
		n = 0;
		while (qTx.size() > 0 && n < 600)
		begin
			@(posedge clk_sys);
			n++;
		end
		if (qTx.size() > 0)
		begin
			err_count++;
			end_sim;
		end
	endtask
	// Receive one message, then check storage and the answer
	task rxCase(input logic [1:0] ctrl, input int n, input bit bad,
		input int junk);
		logic [15:0] lenF;
		logic [7:0] hi;
		wr(BMF_REG_CTRL, {14'h0000, ctrl});
		for (int i = 0; i < n; i++)
		begin
			rnd = nextRnd(rnd);
			i_peer.dat[i] = rnd[7:0];
		end
		lenF = ctrl[1] ? 16'(n) : 16'(n / 2);
		// Refusal is noted before the frame, as it may leave at once
		if (bad)
		begin
			expTx(BMF_NAK);
			expTx(BMF_ERR_SUM[7:0]);
			expTx(BMF_ERR_SUM[15:8]);
		end
		i_peer.msg(lenF, n, ctrl[0], bad, junk);
		repeat (2) @(posedge clk_sys);
		if (bad)
		begin
			waitTx;
			rd(BMF_REG_RXRESULT, BMF_ERR_SUM);
			rd(BMF_REG_STATUS, 16'h0000);
			rd({BMF_RXBUF_REGION, 9'h000}, prev);
		end
		else
		begin
			rd(BMF_REG_STATUS, 16'h0001);
			rd(BMF_REG_RXLEN, lenF);
			for (int i = 0; i < (n + 1) / 2; i++)
			begin
				hi = (2 * i + 1 < n) ? i_peer.dat[2 * i + 1] : 8'h00;
				rd({BMF_RXBUF_REGION, 9'(i)}, {hi, i_peer.dat[2 * i]});
			end
			prev = {i_peer.dat[1], i_peer.dat[0]};
			expTx(BMF_ACK);
			wr(BMF_REG_CMD, 16'h0001);
			waitTx;
			rd(BMF_REG_STATUS, 16'h0000);
		end
	endtask
	// Send one word; the peer answers with an acknowledge or a refusal
	task txCase(input logic [1:0] ctrl, input bit nakIt);
		logic [15:0] w, s;
		wr(BMF_REG_CTRL, {14'h0000, ctrl});
		rnd = nextRnd(rnd);
		w = rnd[15:0];
		wr(BMF_REG_TXLEN, 16'h0001);
		wr({BMF_TXBUF_REGION, 9'h000}, w);
		s = 16'h0001 + 16'(w[7:0]) + 16'(w[15:8]);
		expTx(BMF_ENQ);
		expTx(8'h01);
		expTx(8'h00);
		expTx(w[7:0]);
		expTx(w[15:8]);
		if (ctrl[0])
		begin
			expTx(s[7:0]);
			expTx(s[15:8]);
		end
		wr(BMF_REG_CMD, 16'h0002);
		waitTx;
		if (nakIt)
			i_peer.nak(16'h0030);
		else
			i_peer.put(BMF_ACK);
		repeat (4) @(posedge clk_sys);
		rd(BMF_REG_TXRESULT, nakIt ? 16'h0030 : 16'h0000);
		rd(BMF_REG_STATUS, nakIt ? 16'h0018 : 16'h0008);
	endtask
	// Main sequence
	initial
	begin
		prev = 16'h0000;
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		rd(BMF_REG_CTRL, {14'h0000, BMF_CTRL_RESET});
		rd(BMF_REG_STATUS, 16'h0000);
		wr(12'h0ff, 16'hffff);
		rd(12'h0ff, 16'h0000);
		rxCase(2'h1, 4, 1'b0, 0);
		rxCase(2'h3, 3, 1'b0, 0);
		rxCase(2'h3, 5, 1'b1, 0);
		rxCase(2'h2, 2, 1'b0, 2);
		txCase(2'h1, 1'b1);
		txCase(2'h0, 1'b0);
		end_sim;
	end
endmodule
